/* File: reset_cause_flag_recorder.sv */
// reset-cause flags, brown-out control and core status bits behind an avalon-mm slave
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_map.svh"

module reset_cause_flag_recorder (
    // clock, power-on reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // reset sources and configuration
    input wire reset_cause_pkg::reset_sources_t sources,
    input wire logic stack_reset_enable,
    input wire logic [1:0] brownout_config,
    input wire logic brownout_armed,
    // interrupt wake-up
    input wire logic wake_interrupt,
    input wire logic wake_high_priority,
    input wire logic global_interrupt_enable,
    input wire logic instruction_retired,
    // to core and power control
    output logic core_restart,
    output logic brownout_enable,
    output logic vector_load,
    output logic vector_high
);

    localparam reset_cause_pkg::recorder_state_t STATE_RESET = '{
        waitrequest: 1'b1,
        readdata: 32'h0000_0000,
        causes: `CAUSES_AFTER_POWER_ON,
        regulator_reset_flag: 1'b1,
        config_memory_reset_flag: 1'b1,
        soft_brownout_enable: 1'b1,
        brownout_ready: 1'b0,
        brownout_enable: 1'b0,
        timeout_n: 1'b1,
        powerdown_n: 1'b1,
        zero: 1'b0,
        digit_carry: 1'b0,
        carry: 1'b0,
        core_restart: 1'b0,
        wake_pending: 1'b0,
        wake_high: 1'b0,
        vector_load: 1'b0,
        vector_high: 1'b0
    };

    reset_cause_pkg::recorder_state_t state;
    reset_cause_pkg::recorder_state_t next_state;

    logic [11:0] reg_index;
    logic request;
    logic taken;
    logic write_low;
    logic overflow_hit;
    logic underflow_hit;
    logic violation_hit;
    logic any_restart;
    logic [31:0] read_mux;

    // bus decode and qualified reset causes
    assign reg_index = avs_address[13:2];
    assign request = avs_read | avs_write;
    assign taken = request & ~state.waitrequest;
    assign write_low = taken & avs_write & avs_byteenable[0];
    assign overflow_hit = sources.stack_overflow & stack_reset_enable;
    assign underflow_hit = sources.stack_underflow & stack_reset_enable;
    assign violation_hit = sources.watchdog_clear_instruction & ~sources.window_open;
    assign any_restart = sources.brown_out | sources.external_reset_pin
        | sources.watchdog_timeout | violation_hit | sources.reset_instruction
        | overflow_hit | underflow_hit | sources.regulator_fault;

    // read data selection, unmapped indices read zero
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (reg_index)
            `IDX_POWER_CAUSES: begin
                read_mux[7:0] = state.causes;
            end
            `IDX_POWER_SECONDARY: begin
                read_mux[`BIT_REGULATOR_RESET] = state.regulator_reset_flag;
                read_mux[`BIT_CONFIG_MEMORY_RESET] = state.config_memory_reset_flag;
            end
            `IDX_BROWNOUT_CONTROL: begin
                read_mux[`BIT_SOFT_BROWNOUT_ENABLE] = state.soft_brownout_enable;
                read_mux[`BIT_BROWNOUT_READY] = state.brownout_ready;
            end
            `IDX_CORE_STATUS: begin
                // bits 7, 4 and 3 are not implemented and stay zero
                read_mux[`BIT_TIMEOUT_N] = state.timeout_n;
                read_mux[`BIT_POWERDOWN_N] = state.powerdown_n;
                read_mux[`BIT_ZERO] = state.zero;
                read_mux[`BIT_DIGIT_CARRY] = state.digit_carry;
                read_mux[`BIT_CARRY] = state.carry;
            end
            default: begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    // next state: bus, firmware writes, then hardware causes on top
    always_comb begin
        next_state = state;
        // one wait cycle, then answer for exactly one cycle
        next_state.waitrequest = ~(request & state.waitrequest);
        if (request && state.waitrequest) begin
            next_state.readdata = read_mux;
        end
        // firmware writes store any value and start nothing
        if (write_low) begin
            unique case (reg_index)
                `IDX_POWER_CAUSES: begin
                    next_state.causes = avs_writedata[7:0];
                end
                `IDX_POWER_SECONDARY: begin
                    next_state.regulator_reset_flag = avs_writedata[`BIT_REGULATOR_RESET];
                    next_state.config_memory_reset_flag =
                        avs_writedata[`BIT_CONFIG_MEMORY_RESET];
                end
                `IDX_BROWNOUT_CONTROL: begin
                    next_state.soft_brownout_enable = avs_writedata[`BIT_SOFT_BROWNOUT_ENABLE];
                end
                `IDX_CORE_STATUS: begin
                    next_state.zero = avs_writedata[`BIT_ZERO];
                    next_state.digit_carry = avs_writedata[`BIT_DIGIT_CARRY];
                    next_state.carry = avs_writedata[`BIT_CARRY];
                end
                default: begin
                    next_state.zero = state.zero;
                end
            endcase
        end
        // hardware causes applied last so they win over a write
        if (sources.brown_out) begin
            next_state.causes[7:2] = `CAUSES_UPPER_AFTER_MASTER;
            next_state.causes[`BIT_BROWN_OUT] = 1'b0;
            next_state.soft_brownout_enable = 1'b1;
            next_state.regulator_reset_flag = 1'b1;
            next_state.config_memory_reset_flag = state.config_memory_reset_flag;
            next_state.timeout_n = 1'b1;
            next_state.powerdown_n = 1'b1;
            next_state.zero = 1'b0;
            next_state.digit_carry = 1'b0;
            next_state.carry = 1'b0;
        end else if (sources.regulator_fault) begin
            next_state.causes[7:1] = `CAUSES_UPPER_AFTER_REGULATOR;
            next_state.regulator_reset_flag = 1'b0;
            next_state.config_memory_reset_flag = 1'b1;
        end else begin
            // each cause touches its own flag bit only; the time-out also clears timeout_n
            if (overflow_hit) begin
                next_state.causes[`BIT_STACK_OVERFLOW] = 1'b1;
            end
            if (underflow_hit) begin
                next_state.causes[`BIT_STACK_UNDERFLOW] = 1'b1;
            end
            if (violation_hit) begin
                next_state.causes[`BIT_WINDOW_VIOLATION] = 1'b0;
            end
            if (sources.watchdog_timeout) begin
                next_state.causes[`BIT_WATCHDOG_TIMEOUT] = 1'b0;
                next_state.timeout_n = 1'b0;
            end
            if (sources.external_reset_pin) begin
                next_state.causes[`BIT_PIN_RESET] = 1'b0;
            end
            if (sources.reset_instruction) begin
                next_state.causes[`BIT_RESET_INSTRUCTION] = 1'b0;
            end
        end
        // restart at program counter zero on every reset cause
        next_state.core_restart = any_restart;
        // brown-out enable: soft bit counts only in config 01
        if (brownout_config == `BROWNOUT_CONFIG_SOFT) begin
            next_state.brownout_enable = state.soft_brownout_enable;
        end else begin
            next_state.brownout_enable = brownout_config[1];
        end
        next_state.brownout_ready = state.brownout_enable & brownout_armed;
        // interrupt wake: vector after the next instruction retires
        next_state.vector_load = 1'b0;
        if (state.wake_pending && instruction_retired) begin
            next_state.wake_pending = 1'b0;
            next_state.vector_load = 1'b1;
            next_state.vector_high = state.wake_high;
        end else if (wake_interrupt && global_interrupt_enable && !state.wake_pending) begin
            next_state.wake_pending = 1'b1;
            next_state.wake_high = wake_high_priority;
        end
        if (any_restart) begin
            next_state.wake_pending = 1'b0;
        end
    end

    // single state register; only the power-on reset clears it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= STATE_RESET;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign avs_readdata = state.readdata;
    assign avs_waitrequest = state.waitrequest;
    assign core_restart = state.core_restart;
    assign brownout_enable = state.brownout_enable;
    assign vector_load = state.vector_load;
    assign vector_high = state.vector_high;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence timeout_seen;
        clk_en && sources.watchdog_timeout && !sources.brown_out && !sources.regulator_fault;
    endsequence

    sequence cause_written;
        clk_en && write_low && reg_index == `IDX_POWER_CAUSES;
    endsequence

    timeout_flag_clear_a: assert property (timeout_seen |=> !state.causes[4] && !state.timeout_n)
        else $error("time-out flag not cleared");
    pin_flag_clear_a: assert property (clk_en && sources.external_reset_pin && !sources.brown_out
        && !sources.regulator_fault |=> !state.causes[3])
        else $error("pin reset flag not cleared");
    instr_flag_restart_a: assert property (clk_en && sources.reset_instruction
        |=> core_restart && (sources.brown_out || sources.regulator_fault || !state.causes[2]))
        else $error("reset instruction not recorded");
    overflow_gate_a: assert property (clk_en && sources.stack_overflow && !stack_reset_enable
        && !any_restart && !write_low |=> $stable(state.causes[7]) && !core_restart)
        else $error("overflow acted while disabled");
    master_reset_values_a: assert property (clk_en && sources.brown_out
        |=> state.causes[7:2] == 6'h0f && !state.causes[0] && state.soft_brownout_enable
        && !state.zero && !state.carry)
        else $error("master reset values wrong");
    no_self_clear_a: assert property (clk_en && !write_low && !sources.brown_out
        && !sources.regulator_fault |=> !$rose(state.causes[5]) && !$fell(state.causes[7]))
        else $error("flag returned to inactive by hardware");
    write_no_restart_a: assert property (cause_written and !any_restart
        |=> state.causes == $past(avs_writedata[7:0]) && !core_restart)
        else $error("firmware write misbehaved");
    write_loses_a: assert property (cause_written ##0 timeout_seen |=> !state.causes[4])
        else $error("write beat hardware cause");
    // arst_n in the antecedent keeps the release edge out: the register
    // still takes its reset value there, so the previous state does not apply
    soft_enable_gate_a: assert property (arst_n && clk_en && brownout_config == 2'h1
        |=> brownout_enable == $past(state.soft_brownout_enable))
        else $error("soft brown-out enable ignored");
    ready_tracks_a: assert property (clk_en ##1 clk_en
        |=> state.brownout_ready == ($past(brownout_enable) && $past(brownout_armed)))
        else $error("brown-out ready wrong");
    bus_answer_a: assert property (arst_n && clk_en && request && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");

    // further checks on single causes, bus answer and wake-up
    sequence violation_seen;
        clk_en && violation_hit && !sources.brown_out && !sources.regulator_fault;
    endsequence

    sequence wake_armed;
        clk_en && wake_interrupt && global_interrupt_enable && !state.wake_pending
            && !any_restart;
    endsequence

    // wake seen, two cycles without retire, then the retiring instruction
    sequence wake_then_retire;
        wake_armed ##1 (clk_en && !instruction_retired && !any_restart) [*2]
            ##1 (clk_en && instruction_retired && !any_restart);
    endsequence

    violation_flag_clear_a: assert property (violation_seen
        |=> !state.causes[5] && core_restart)
        else $error("window violation not recorded");
    window_open_quiet_a: assert property (clk_en && sources.watchdog_clear_instruction
        && sources.window_open && !any_restart && !write_low
        |=> $stable(state.causes[5]) && !core_restart)
        else $error("clear inside window acted");
    overflow_flag_set_a: assert property (clk_en && overflow_hit && !sources.brown_out
        && !sources.regulator_fault |=> state.causes[7] && core_restart)
        else $error("overflow not recorded");
    underflow_flag_set_a: assert property (clk_en && underflow_hit && !sources.brown_out
        && !sources.regulator_fault |=> state.causes[6] && core_restart)
        else $error("underflow not recorded");
    pin_only_own_a: assert property (clk_en && sources.external_reset_pin && !write_low
        && !sources.brown_out && !sources.regulator_fault && !sources.watchdog_timeout
        && !violation_hit && !sources.reset_instruction && !overflow_hit && !underflow_hit
        |=> state.causes[7:4] == $past(state.causes[7:4])
        && state.causes[2:0] == $past(state.causes[2:0]))
        else $error("pin reset touched other flags");
    regulator_values_a: assert property (clk_en && sources.regulator_fault
        && !sources.brown_out |=> state.causes[7:1] == `CAUSES_UPPER_AFTER_REGULATOR
        && !state.regulator_reset_flag)
        else $error("regulator fault values wrong");
    master_side_values_a: assert property (clk_en && sources.brown_out
        |=> state.regulator_reset_flag && state.timeout_n && state.powerdown_n
        && !state.digit_carry)
        else $error("master reset side values wrong");
    status_zero_bits_a: assert property (clk_en && request && state.waitrequest
        && reg_index == `IDX_CORE_STATUS |=> avs_readdata[31:8] == 24'h00_0000
        && !avs_readdata[7] && avs_readdata[4:3] == 2'h0)
        else $error("unimplemented status bits set");
    answer_one_cycle_a: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    ready_disabled_a: assert property (clk_en && !brownout_enable
        |=> !state.brownout_ready)
        else $error("ready while brown-out disabled");
    wake_pending_a: assert property (wake_armed
        |=> state.wake_pending && state.wake_high == $past(wake_high_priority))
        else $error("wake not held");
    vector_after_retire_a: assert property (wake_then_retire
        |=> vector_load && vector_high == $past(wake_high_priority, 4))
        else $error("vector not loaded after next instruction");
    no_stray_vector_a: assert property (clk_en && !state.wake_pending |=> !vector_load)
        else $error("vector without wake");
    restart_cancels_a: assert property (clk_en && any_restart |=> !state.wake_pending)
        else $error("wake survived restart");

endmodule : reset_cause_flag_recorder
`default_nettype wire

/* File: reset_cause_map.svh */
// register indices, field positions, reset values and timing counts of the reset-cause block
`ifndef RESET_CAUSE_MAP_SVH
`define RESET_CAUSE_MAP_SVH

// register indices; the byte address is four times the index
`define IDX_BROWNOUT_CONTROL 12'hedb
`define IDX_POWER_SECONDARY 12'hfd6
`define IDX_POWER_CAUSES 12'hfd7
`define IDX_CORE_STATUS 12'hfd8

// power_control_reset_causes fields
`define BIT_STACK_OVERFLOW 7
`define BIT_STACK_UNDERFLOW 6
`define BIT_WINDOW_VIOLATION 5
`define BIT_WATCHDOG_TIMEOUT 4
`define BIT_PIN_RESET 3
`define BIT_RESET_INSTRUCTION 2
`define BIT_POWER_ON 1
`define BIT_BROWN_OUT 0

// power_control_secondary fields
`define BIT_REGULATOR_RESET 2
`define BIT_CONFIG_MEMORY_RESET 0

// brownout_control fields
`define BIT_SOFT_BROWNOUT_ENABLE 7
`define BIT_BROWNOUT_READY 0

// core status fields
`define BIT_TIMEOUT_N 6
`define BIT_POWERDOWN_N 5
`define BIT_ZERO 2
`define BIT_DIGIT_CARRY 1
`define BIT_CARRY 0

// reset values after power-on (unknown brown-out flag taken as 1)
`define CAUSES_AFTER_POWER_ON 8'h3d
// upper six cause bits after brown-out, upper seven after regulator fault
`define CAUSES_UPPER_AFTER_MASTER 6'h0f
`define CAUSES_UPPER_AFTER_REGULATOR 7'h19
`define BROWNOUT_CONFIG_SOFT 2'h1

// bus answer latency in cycles after the request is first seen
`define BUS_ANSWER_CYCLES 1

`endif

/* File: reset_cause_pkg.sv */
// types shared by the reset-cause recorder
package reset_cause_pkg;

    // all state of the recorder
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [7:0] causes;
        logic regulator_reset_flag;
        logic config_memory_reset_flag;
        logic soft_brownout_enable;
        logic brownout_ready;
        logic brownout_enable;
        logic timeout_n;
        logic powerdown_n;
        logic zero;
        logic digit_carry;
        logic carry;
        logic core_restart;
        logic wake_pending;
        logic wake_high;
        logic vector_load;
        logic vector_high;
    } recorder_state_t;

    // reset-source pulses from the rest of the chip
    typedef struct packed {
        logic brown_out;
        logic external_reset_pin;
        logic watchdog_timeout;
        logic watchdog_clear_instruction;
        logic window_open;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic regulator_fault;
    } reset_sources_t;

endpackage : reset_cause_pkg

/* File: reset_event_model.sv */
// partner model: on-chip reset event sources as one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module reset_event_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // event request from the core side
    input wire logic event_go,
    input wire logic [3:0] event_code,
    input wire logic window_open_in,
    // pulses towards the recorder
    output var reset_cause_pkg::reset_sources_t sources
);
    // one pulse per request, window level passed through
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sources <= '0;
        end else begin
            sources <= '0;
            sources.window_open <= window_open_in;
            if (event_go) begin
                case (event_code)
                    4'h0: sources.watchdog_timeout <= 1'b1;
                    4'h1: sources.watchdog_clear_instruction <= 1'b1;
                    4'h2: sources.external_reset_pin <= 1'b1;
                    4'h3: sources.reset_instruction <= 1'b1;
                    4'h4: sources.stack_overflow <= 1'b1;
                    4'h5: sources.stack_underflow <= 1'b1;
                    4'h6: sources.brown_out <= 1'b1;
                    default: sources.regulator_fault <= 1'b1;
                endcase
            end
        end
    end
endmodule : reset_event_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the reset-cause recorder
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_map.svh"
module testbench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [13:0] avs_address = 14'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    reset_cause_pkg::reset_sources_t sources;
    logic stack_reset_enable = 1'b1;
    logic [1:0] brownout_config = 2'h1;
    logic brownout_armed = 1'b1;
    logic wake_interrupt = 1'b0;
    logic wake_high_priority = 1'b0;
    logic global_interrupt_enable = 1'b1;
    logic instruction_retired = 1'b0;
    logic clk_en = 1'b1;
    logic core_restart, brownout_enable, vector_load, vector_high;
    logic event_go = 1'b0;
    logic [3:0] event_code = 4'h0;
    logic window_open_in = 1'b1;
    int failures = 0;
    int checks = 0;
    int restarts = 0;
    int loads = 0;
    int rs;
    logic [7:0] rd;
    localparam logic [13:0] bor = {`IDX_BROWNOUT_CONTROL, 2'b00};
    localparam logic [13:0] sec = {`IDX_POWER_SECONDARY, 2'b00};
    localparam logic [13:0] cau = {`IDX_POWER_CAUSES, 2'b00};
    localparam logic [13:0] sta = {`IDX_CORE_STATUS, 2'b00};
    // cause table: event code and flags expected from clean flags
    localparam logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h1, 4'h4, 4'h0};
    localparam logic [7:0] expc [8] = '{8'h1f, 8'h37, 8'h3b, 8'hbf, 8'h7f, 8'h3f, 8'h3f, 8'h2f};

    // clock
    always #50 ref_clk = ~ref_clk;

    // count restart and vector pulses
    always @(posedge ref_clk) begin
        if (core_restart === 1'b1) restarts++;
        if (vector_load === 1'b1) loads++;
    end

    reset_event_model i_reset_event_model (.ref_clk(ref_clk), .arst_n(arst_n),
        .event_go(event_go), .event_code(event_code), .window_open_in(window_open_in),
        .sources(sources));

    reset_cause_flag_recorder i_reset_cause_flag_recorder (.ref_clk(ref_clk),
        .arst_n(arst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sources(sources),
        .stack_reset_enable(stack_reset_enable), .brownout_config(brownout_config),
        .brownout_armed(brownout_armed), .wake_interrupt(wake_interrupt),
        .wake_high_priority(wake_high_priority),
        .global_interrupt_enable(global_interrupt_enable),
        .instruction_retired(instruction_retired), .core_restart(core_restart),
        .brownout_enable(brownout_enable), .vector_load(vector_load),
        .vector_high(vector_high));

    task give_verdict;
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [13:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("mismatch at %0t: bus answer timeout", $time);
            give_verdict();
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rdchk(input logic [13:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        check(rd, exp, what);
    endtask : rdchk

    // request one reset event from the partner
    task fire(input logic [3:0] c);
        @(posedge ref_clk);
        event_code <= c;
        event_go <= 1'b1;
        @(posedge ref_clk);
        event_go <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : fire

    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rdchk(cau, 8'h3d, "causes after power-on");
        rdchk(sec, 8'h05, "secondary after power-on");
        rdchk(bor, 8'h81, "brown-out control after power-on");
        rdchk(sta, 8'h60, "status after power-on");
        bus(1'b1, cau, 8'hc0);
        rdchk(cau, 8'hc0, "firmware-set flags");
        check(8'(restarts), 8'h00, "restart from firmware write");
        for (int i = 0; i < 8; i++) begin
            window_open_in <= (i == 5);
            stack_reset_enable <= (i != 6);
            bus(1'b1, cau, 8'h3f);
            bus(1'b1, sta, 8'h07);
            rs = restarts;
            fire(codes[i]);
            rdchk(cau, expc[i], "cause flags");
            rdchk(sta, (i == 7) ? 8'h27 : 8'h67, "status after cause");
            check(8'(restarts - rs), {7'h0, i < 5 || i == 7}, "restart pulses");
        end
        fork
            bus(1'b1, cau, 8'h3f);
            fire(4'h0);
        join
        rdchk(cau, 8'h2f, "cause beats write");
        repeat (20) @(posedge ref_clk);
        rdchk(cau, 8'h2f, "flags persist");
        bus(1'b1, cau, 8'hc2);
        bus(1'b1, bor, 8'h00);
        bus(1'b1, sec, 8'h00);
        fire(4'h6);
        rdchk(cau, 8'h3e, "causes after brown-out");
        rdchk(bor, 8'h81, "soft enable after brown-out");
        rdchk(sta, 8'h60, "status after brown-out");
        bus(1'b0, sec, 8'h00);
        check(rd & 8'h04, 8'h04, "regulator flag after brown-out");
        fire(4'h7);
        rdchk(cau, 8'h32, "causes after regulator fault");
        bus(1'b0, sec, 8'h00);
        check(rd & 8'h04, 8'h00, "regulator flag after fault");
        bus(1'b1, bor, 8'h00);
        repeat (3) @(posedge ref_clk);
        check({7'h0, brownout_enable}, 8'h00, "soft disable");
        rdchk(bor, 8'h00, "ready while disabled");
        brownout_config <= 2'h2;
        repeat (3) @(posedge ref_clk);
        check({7'h0, brownout_enable}, 8'h01, "soft bit ignored");
        rdchk(bor, 8'h01, "ready while armed");
        brownout_armed <= 1'b0;
        brownout_config <= 2'h0;
        bus(1'b1, bor, 8'h81);
        check({7'h0, brownout_enable}, 8'h00, "config off");
        rdchk(bor, 8'h80, "ready is read-only");
        brownout_config <= 2'h1;
        brownout_armed <= 1'b1;
        bus(1'b1, sta, 8'hff);
        rdchk(sta, 8'h67, "unimplemented status bits");
        bus(1'b1, 14'h0000, 8'hff);
        rdchk(14'h0000, 8'h00, "unmapped read");
        avs_byteenable <= 4'h0;
        bus(1'b1, cau, 8'h00);
        avs_byteenable <= 4'h1;
        rdchk(cau, 8'h32, "write without byte enable");
        clk_en <= 1'b0;
        rs = restarts;
        fire(4'h2);
        clk_en <= 1'b1;
        rdchk(cau, 8'h32, "pin pulse while frozen");
        check(8'(restarts - rs), 8'h00, "restart while frozen");
        for (int j = 0; j < 3; j++) begin
            rs = loads;
            @(posedge ref_clk);
            global_interrupt_enable <= (j != 2);
            wake_high_priority <= (j == 0);
            wake_interrupt <= 1'b1;
            @(posedge ref_clk);
            wake_interrupt <= 1'b0;
            repeat (2) @(posedge ref_clk);
            instruction_retired <= 1'b1;
            @(posedge ref_clk);
            instruction_retired <= 1'b0;
            repeat (3) @(posedge ref_clk);
            check(8'(loads - rs), {7'h0, j != 2}, "vector loads");
            if (j != 2) check({7'h0, vector_high}, {7'h0, j == 0}, "vector priority");
        end
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rdchk(cau, 8'h3d, "causes after second power-on");
        rdchk(sec, 8'h05, "secondary after second power-on");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
